//--- core/blt_transceiver.sv
// Two-way 18-bit transceiver with transparent, latched and clocked modes per direction
`timescale 1ns/1ps

// Overview of operation
// R01: Each direction carries an 18-bit word between left and right ports with its own storage.
// R02: With forward latch enable high the left data passes to the right outputs whatever the capture clock does.
// R03: With forward latch enable low and a steady capture clock the stored forward word is held.
// R04: With forward latch enable low each rising edge of the forward capture clock stores the left word.
// R05: With latch enable low and clock high the old level holds only if the clock was high before enable fell.
// R06: Forward output enable high drives the right outputs with the forward path value.
// R07: Forward output enable low releases the right outputs regardless of latch, clock and data.
// R08: The reverse path behaves the same using its own enable, latch enable and capture clock.
// R09: Forward output enable is active high and reverse output enable is active low.
// R10: Each undriven data input keeps its last valid level through bus-hold.
// R11: The controlling logic must not enable both directions at once on a port pair.
module blt_transceiver (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Forward controls
    input wire logic fwd_output_enable,
    input wire logic fwd_latch_enable,
    input wire logic fwd_capture_clock,
    // Reverse controls
    input wire logic rev_output_enable_n,
    input wire logic rev_latch_enable,
    input wire logic rev_capture_clock,
    // Left port pins
    input wire blt_pkg::blt_word_t left_in,
    output blt_pkg::blt_word_t left_out,
    output blt_pkg::blt_word_t left_oe,
    // Right port pins
    input wire blt_pkg::blt_word_t right_in,
    output blt_pkg::blt_word_t right_out,
    output blt_pkg::blt_word_t right_oe
);
    import blt_pkg::*;

    // What the storage of one direction does on this clock edge
    typedef enum logic [1:0] {
        BLT_MODE_HOLD = 2'b00,
        BLT_MODE_PASS = 2'b01,
        BLT_MODE_CAPTURE = 2'b10
    } blt_mode_e;

    blt_ctrl_s ctrl [2];
    blt_word_t din [2];
    blt_drive_s drv [2];

    // Index 0 is forward (left to right), index 1 is reverse
    always_comb
    begin
        ctrl[0] = '{oe: fwd_output_enable, le: fwd_latch_enable, cap_clk: fwd_capture_clock};
        ctrl[1] = '{oe: ~rev_output_enable_n, le: rev_latch_enable, cap_clk: rev_capture_clock}; // R09
        din[0] = left_in;
        din[1] = right_in;
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_dir // R08
            // Input pin sampling with bus-hold
            blt_word_t hold_r;
            blt_word_t hold_nxt;
            logic busy_r;
            logic busy_nxt;
            // Capture clock edge detection
            logic clk_q_r;
            logic clk_q_nxt;
            logic cap_rise;
            blt_mode_e mode;
            // Storage of this direction
            blt_word_t word_r;
            blt_word_t word_nxt;
            // Registered drive of the far port
            blt_drive_s drv_r;
            blt_drive_s drv_nxt;

            // The port read here is driven by the other direction; its enable is copied locally
            // so the copy tracks the other direction's registered enable edge for edge
            always_comb
            begin
                busy_nxt = ctrl[1-g].oe;
                hold_nxt = hold_r; // R10
                if (!busy_r)
                begin
                    hold_nxt = din[g]; // R10
                end
            end

            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    busy_r <= BLT_OE_OFF;
                    hold_r <= BLT_WORD_RST;
                end
                else
                begin
                    busy_r <= busy_nxt;
                    hold_r <= hold_nxt;
                end
            end

            // A rising edge needs a low sample then a high one, so a clock already high
            // when the latch enable falls never captures
            always_comb
            begin
                clk_q_nxt = ctrl[g].cap_clk;
                cap_rise = ctrl[g].cap_clk && !clk_q_r; // R04 R05
            end

            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    clk_q_r <= BLT_CLK_RST;
                end
                else
                begin
                    clk_q_r <= clk_q_nxt;
                end
            end

            // Latch enable wins over the capture clock
            always_comb
            begin
                if (ctrl[g].le)
                begin
                    mode = BLT_MODE_PASS; // R02
                end
                else if (cap_rise)
                begin
                    mode = BLT_MODE_CAPTURE; // R04
                end
                else
                begin
                    mode = BLT_MODE_HOLD; // R03
                end
            end

            always_comb
            begin
                word_nxt = word_r;
                case (mode)
                    BLT_MODE_PASS:
                    begin
                        word_nxt = hold_r; // R02
                    end
                    BLT_MODE_CAPTURE:
                    begin
                        word_nxt = hold_r; // R04
                    end
                    BLT_MODE_HOLD:
                    begin
                        word_nxt = word_r; // R03 R05
                    end
                    default:
                    begin
                        word_nxt = word_r;
                    end
                endcase
            end

            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    word_r <= BLT_WORD_RST;
                end
                else
                begin
                    word_r <= word_nxt;
                end
            end

            // Path value is the transparent word when open, else the stored one
            always_comb
            begin
                drv_nxt.dout = word_r; // R01
                if (mode == BLT_MODE_PASS)
                begin
                    drv_nxt.dout = hold_r; // R02
                end
                drv_nxt.oe = {BLT_WIDTH{BLT_OE_OFF}}; // R07
                if (ctrl[g].oe)
                begin
                    drv_nxt.oe = {BLT_WIDTH{1'b1}}; // R06
                end
            end

            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    drv_r <= '{dout: BLT_WORD_RST, oe: {BLT_WIDTH{BLT_OE_OFF}}};
                end
                else
                begin
                    drv_r <= drv_nxt;
                end
            end

            assign drv[g] = drv_r;
        end
    endgenerate

    // Outputs straight from the drive flip-flops; R11 is left to the controller
    assign right_out = drv[0].dout;
    assign right_oe = drv[0].oe;
    assign left_out = drv[1].dout;
    assign left_oe = drv[1].oe;
endmodule

//--- core/blt_pkg.sv
// Package for the two-way latched bus transceiver: widths, reset values and port carriers
package blt_pkg;
    localparam int BLT_WIDTH = 18;
    localparam logic [17:0] BLT_WORD_RST = 18'h00000;
    localparam logic BLT_CLK_RST = 1'b0;
    localparam logic BLT_OE_OFF = 1'b0;
    localparam logic BLT_OEN_OFF = 1'b1;

    typedef logic [BLT_WIDTH-1:0] blt_word_t;

    // Controls of one direction, enable already in active-high form
    typedef struct packed {
        logic oe;
        logic le;
        logic cap_clk;
    } blt_ctrl_s;

    // One side of a two-way pin group
    typedef struct packed {
        blt_word_t dout;
        logic [BLT_WIDTH-1:0] oe;
    } blt_drive_s;
endpackage

//--- dv/blt_far_side.sv
// Far-side logic on one port, resolving the shared wire
`timescale 1ns/1ps
module blt_far_side (input blt_pkg::blt_word_t d, e, v, output blt_pkg::blt_word_t p);
    // Far side yields wherever the block drives, so no bit ever sees contention
    assign p = (e & d) | (~e & v);
endmodule

//--- dv/blt_chk_sva.sv
// Port assertions for the transceiver
`timescale 1ns/1ps
module blt_chk_sva (input logic sys_clk, rstn, fwd_output_enable, fwd_latch_enable, fwd_capture_clock,
    rev_output_enable_n, rev_latch_enable, rev_capture_clock,
    input blt_pkg::blt_word_t left_in, left_out, left_oe, right_in, right_out, right_oe);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_fwd_on: assert property (fwd_output_enable |=> &right_oe) else $error("oe");
    chk_fwd_off: assert property (!fwd_output_enable |=> !right_oe) else $error("oe");
    chk_rev_on: assert property (!rev_output_enable_n |=> &left_oe) else $error("oe");
    chk_rev_off: assert property (rev_output_enable_n |=> !left_oe) else $error("oe");
    chk_fwd_pass: assert property ((fwd_latch_enable && $stable(left_in) && !left_oe)[*3]
        |-> right_out == left_in) else $error("pass");
    chk_rev_pass: assert property ((rev_latch_enable && $stable(right_in) && !right_oe)[*3]
        |-> left_out == right_in) else $error("pass");
    chk_fwd_hold: assert property ((!fwd_latch_enable && $stable(fwd_capture_clock))[*4]
        |-> $stable(right_out)) else $error("hold");
    chk_fwd_cap: assert property ((!fwd_latch_enable && $rose(fwd_capture_clock) && $stable(left_in)
        && $past(rstn) && !left_oe && !$past(left_oe)) ##1 !fwd_latch_enable[*2]
        |-> right_out == $past(left_in, 2)) else $error("cap");
    chk_rev_hold: assert property ((!rev_latch_enable && $stable(rev_capture_clock))[*4]
        |-> $stable(left_out)) else $error("hold");
    chk_rev_cap: assert property ((!rev_latch_enable && $rose(rev_capture_clock) && $stable(right_in)
        && $past(rstn) && !right_oe && !$past(right_oe)) ##1 !rev_latch_enable[*2]
        |-> left_out == $past(right_in, 2)) else $error("cap");
endmodule

//--- dv/blt_transceiver_tb.sv
// Bench for the transceiver modes in both directions
`timescale 1ns/1ps
module blt_transceiver_tb;
    import blt_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic fwd_output_enable, fwd_latch_enable, fwd_capture_clock;
    logic rev_output_enable_n, rev_latch_enable, rev_capture_clock;
    blt_word_t left_in, left_out, left_oe, right_in, right_out, right_oe, lv, rv;
    int n_errors = 0;
    int compares = 0;
    always #25 sys_clk = ~sys_clk;
    blt_transceiver dut (.sys_clk(sys_clk), .rstn(rstn), .fwd_output_enable(fwd_output_enable),
        .fwd_latch_enable(fwd_latch_enable), .fwd_capture_clock(fwd_capture_clock),
        .rev_output_enable_n(rev_output_enable_n), .rev_latch_enable(rev_latch_enable),
        .rev_capture_clock(rev_capture_clock), .left_in(left_in), .left_out(left_out), .left_oe(left_oe),
        .right_in(right_in), .right_out(right_out), .right_oe(right_oe));
    blt_far_side u_l (.d(left_out), .e(left_oe), .v(lv), .p(left_in));
    blt_far_side u_r (.d(right_out), .e(right_oe), .v(rv), .p(right_in));
    // Control word: fwd oe, le, clk, then rev oe_n, le, clk; no caller enables both directions
    task automatic drv(logic [5:0] c, blt_word_t l, blt_word_t r);
        {fwd_output_enable, fwd_latch_enable, fwd_capture_clock} = c[5:3];
        {rev_output_enable_n, rev_latch_enable, rev_capture_clock, lv, rv} = {c[2:0], l, r};
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic chk(blt_word_t e, blt_word_t g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic t_fwd;
        drv(6'o64, 18'h2AB5C, 18'h0);
        chk(18'h2AB5C, right_out);
        chk(18'h3FFFF, right_oe);
        drv(6'o44, 18'h2AB5C, 18'h0);
        drv(6'o44, 18'h015A3, 18'h0);
        chk(18'h2AB5C, right_out);
        drv(6'o54, 18'h015A3, 18'h0);
        chk(18'h015A3, right_out);
        drv(6'o04, 18'h0, 18'h0);
        chk(18'h00000, right_oe);
        drv(6'o65, 18'h1D2E4, 18'h0);
        chk(18'h1D2E4, right_out);
        drv(6'o45, 18'h0B7C8, 18'h0);
        chk(18'h1D2E4, right_out);
        drv(6'o04, 18'h0, 18'h0);
    endtask
    task automatic t_rev;
        drv(6'o22, 18'h2468A, 18'h3C0F1);
        drv(6'o22, 18'h2468A, 18'h3C0F1);
        chk(18'h3C0F1, left_out);
        chk(18'h3FFFF, left_oe);
        chk(18'h2468A, right_out);
        drv(6'o00, 18'h2468A, 18'h12345);
        chk(18'h3C0F1, left_out);
        drv(6'o01, 18'h2468A, 18'h12345);
        chk(18'h12345, left_out);
        drv(6'o04, 18'h0, 18'h0);
        chk(18'h00000, left_oe);
    endtask
    task automatic t_reset;
        drv(6'o64, 18'h0F0F0, 18'h0);
        rstn = 1'b0;
        @(negedge sys_clk);
        chk(18'h00000, right_oe);
        chk(18'h00000, right_out);
        rstn = 1'b1;
        drv(6'o64, 18'h0F0F0, 18'h0);
        chk(18'h0F0F0, right_out);
        chk(18'h3FFFF, right_oe);
        drv(6'o04, 18'h0, 18'h0);
    endtask
    task automatic complete_run(int x);
        n_errors += x;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        drv(6'o04, 18'h0, 18'h0);
        @(negedge sys_clk);
        rstn = 1'b1;
        t_fwd;
        t_rev;
        t_reset;
        complete_run(0);
    end
    // Several times the roughly 53 cycles the scenarios need
    initial #20000 complete_run(1);
endmodule
bind blt_transceiver blt_chk_sva u_chk (.sys_clk(sys_clk), .rstn(rstn), .fwd_output_enable(fwd_output_enable),
    .fwd_latch_enable(fwd_latch_enable), .fwd_capture_clock(fwd_capture_clock),
    .rev_output_enable_n(rev_output_enable_n), .rev_latch_enable(rev_latch_enable),
    .rev_capture_clock(rev_capture_clock), .left_in(left_in), .left_out(left_out), .left_oe(left_oe),
    .right_in(right_in), .right_out(right_out), .right_oe(right_oe));
